// File: hdl/irq_flags_defines.svh
/*
 Register offsets, field positions, reset values and interrupt numbers
 for the interrupt flag and priority block.
 Assumes a Wishbone slave with byte addresses and 32-bit words.
*/
// Summary of operation
// - Flags four: bit 7 sleep timer pending, bit 5 port zero pending.
// - Timer 1..4 flags set by hardware, cleared when CPU vectors to them.
// - Flags four bit 0 shows DMA complete pending.
// - Flags five bit 4 is watchdog pending; bits 7:5 unused, read 0.
// - Flags five bit 3 shows port one pending.
// - Flags five bit 2 shared by second serial transmit and audio transmit.
// - Flags five bit 1 shows first serial unit transmit pending.
// - Flags five bit 0 shared by port two and USB controller.
// - Six priority groups, two registers with one bit per group.
// - Four levels per group, all groups lowest after reset.
// - Active routine blocks requests at equal or lower level.
// - Equal-level simultaneous requests resolved by fixed polling order.
// - Level is {high bit, low bit}; 00 lowest, 11 highest.
`ifndef IRQ_FLAGS_DEFINES_SVH
`define IRQ_FLAGS_DEFINES_SVH

// Register byte offsets
`define OFS_FLAGS_FOUR    8'hC0
`define OFS_FLAGS_FIVE    8'hE8
`define OFS_PRIO_LOW      8'hD0
`define OFS_PRIO_HIGH     8'hD4
`define OFS_SERVICE       8'hD8

// Flags four bit positions
`define BIT_SLEEP_TIMER   7
`define BIT_RESERVED_SIX  6
`define BIT_PORT_ZERO     5
`define BIT_TIMER_FOUR    4
`define BIT_TIMER_THREE   3
`define BIT_TIMER_TWO     2
`define BIT_TIMER_ONE     1
`define BIT_DMA_DONE      0

// Flags five bit positions
`define BIT_WATCHDOG      4
`define BIT_PORT_ONE      3
`define BIT_SERIAL_B_TX   2
`define BIT_SERIAL_A_TX   1
`define BIT_PORT_TWO      0
`define MASK_FLAGS_FIVE   8'h1F

// Reset values
`define RST_FLAGS         8'h00
`define RST_PRIO          6'h00

// Interrupt numbers of the flags held here
`define NUM_DMA           5'h08
`define NUM_TIMER_ONE     5'h09
`define NUM_TIMER_TWO     5'h0A
`define NUM_TIMER_THREE   5'h0B
`define NUM_TIMER_FOUR    5'h0C
`define NUM_PORT_ZERO     5'h0D
`define NUM_SLEEP_TIMER   5'h05
`define NUM_PORT_TWO      5'h06
`define NUM_SERIAL_A_TX   5'h07
`define NUM_SERIAL_B_TX   5'h0E
`define NUM_PORT_ONE      5'h0F
`define NUM_WATCHDOG      5'h11

`endif

// File: hdl/irq_flags_pkg.sv
/*
 Types shared by the interrupt flag and priority block.
 Assumes the defines header is included where constants are needed.
*/
package irq_flags_pkg;

    // Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    // Wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;

    // Hardware request pulses from the sources
    typedef struct packed {
        logic sleepTimer;
        logic portZero;
        logic timerFour;
        logic timerThree;
        logic timerTwo;
        logic timerOne;
        logic dmaDone;
        logic watchdog;
        logic portOne;
        logic serialBTx;
        logic audioTx;
        logic serialATx;
        logic portTwo;
        logic usbCtrl;
    } hw_set_t;

    typedef logic [1:0] level_t;

    // Request presented to the processor core
    typedef struct packed {
        logic       req;
        logic [4:0] num;
        level_t     level;
    } irq_out_t;

endpackage

// File: hdl/irq_flags_and_priority.sv
/*
 Interrupt flag registers four and five plus group priority resolution.
 Holds the flags, the two priority registers and the nesting state,
 and presents the winning request to the processor core.
 Assumes sources give one-cycle pulses on core_clk, the core pulses
 vectorAck when it takes the presented number and retiPulse on return,
 and flags of other sources arrive as levels on otherPending.
*/
`timescale 1ns/1ps
`include "irq_flags_defines.svh"
`default_nettype none

module irq_flags_and_priority
    import irq_flags_pkg::*;
#(
    parameter int NUM_IRQS   = 18,
    parameter int NUM_GROUPS = 6
) (
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    input  wire wb_req_t           wbReq,
    output var  wb_rsp_t           wbRsp,
    input  wire hw_set_t           hwSet,
    input  wire logic [17:0]       otherPending,
    input  wire logic              vectorAck,
    input  wire logic              retiPulse,
    output var  irq_out_t          irqOut,
    output var  logic [3:0]        activeLevels
);

    // Polling order and grouping are fixed for this many sources,
    // so any other count is refused while the design is built
    if (NUM_IRQS != 18 || NUM_GROUPS != 6) begin : gParamCheck
        $error("irq_flags_and_priority serves 18 sources in 6 groups");
    end

    ////////////////////////////////////////////////////////////////////
    // Decoding functions

    // Interrupt number at a given place in the polling sequence
    function automatic logic [4:0] pollNum(input logic [4:0] place);
        logic [4:0] n;
        n = 5'h00;
        // Places past the last source fall back to 0
        case (place)
            5'h00: n = 5'h00;
            5'h01: n = 5'h10;
            5'h02: n = 5'h08;
            5'h03: n = 5'h01;
            5'h04: n = 5'h09;
            5'h05: n = 5'h02;
            5'h06: n = 5'h0A;
            5'h07: n = 5'h03;
            5'h08: n = 5'h0B;
            5'h09: n = 5'h04;
            5'h0A: n = 5'h0C;
            5'h0B: n = 5'h05;
            5'h0C: n = 5'h0D;
            5'h0D: n = 5'h06;
            5'h0E: n = 5'h07;
            5'h0F: n = 5'h0E;
            5'h10: n = 5'h0F;
            5'h11: n = 5'h11;
            default: n = 5'h00;
        endcase
        return n;
    endfunction

    // Priority group of an interrupt number
    function automatic logic [2:0] groupOf(input logic [4:0] num);
        logic [2:0] g;
        g = 3'h0;
        case (num)
            5'h06: g = 3'h1;
            5'h07: g = 3'h2;
            5'h0E: g = 3'h3;
            5'h0F: g = 3'h4;
            5'h10: g = 3'h0;
            5'h11: g = 3'h5;
            default: g = num[2:0];
        endcase
        return g;
    endfunction

    // Highest level held in a nesting mask
    // Levels nest upward, so the top bit is the innermost
    function automatic level_t topLevel(input logic [3:0] mask);
        level_t t;
        t = 2'h0;
        for (int k = 0; k < 4; k++) begin
            if (mask[k]) begin
                t = level_t'(k);
            end
        end
        return t;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Bus slave

    logic        ackReg;
    logic        ackNext;
    logic [31:0] rdReg;
    logic [31:0] rdNext;
    logic        wrLow;
    logic [7:0]  wrData;

    // Register state and next values
    logic [7:0]  flagsFourReg;
    logic [7:0]  flagsFourNext;
    logic [7:0]  flagsFiveReg;
    logic [7:0]  flagsFiveNext;
    logic [5:0]  prioLowReg;
    logic [5:0]  prioLowNext;
    logic [5:0]  prioHighReg;
    logic [5:0]  prioHighNext;
    logic [3:0]  activeReg;
    logic [3:0]  activeNext;
    irq_out_t    irqReg;
    irq_out_t    irqNext;

    // Answer one cycle after the strobe; ack drops the cycle after
    // Writes commit at the edge on which ack rises
    always_comb begin
        ackNext = wbReq.cyc & wbReq.stb & ~ackReg;
        wrLow   = ackNext & wbReq.we & wbReq.sel[0];
        wrData  = wbReq.dat[7:0];
        rdNext  = 32'h0000_0000;
        if (ackNext && !wbReq.we) begin
            case (wbReq.adr)
                `OFS_FLAGS_FOUR: rdNext = {24'h00_0000, flagsFourReg};
                `OFS_FLAGS_FIVE: rdNext = {24'h00_0000, flagsFiveReg};
                `OFS_PRIO_LOW:   rdNext = {26'h000_0000, prioLowReg};
                `OFS_PRIO_HIGH:  rdNext = {26'h000_0000, prioHighReg};
                `OFS_SERVICE:    rdNext = {16'h0000, 1'b0, irqReg.num,
                                           irqReg.level, 4'h0, activeReg};
                default:         rdNext = 32'h0000_0000;
            endcase
        end
    end

    // Bus answer registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ackReg <= 1'b0;
            rdReg  <= 32'h0000_0000;
        end else begin
            ackReg <= ackNext;
            rdReg  <= rdNext;
        end
    end

    assign wbRsp.ack = ackReg;
    assign wbRsp.dat = rdReg;

    ////////////////////////////////////////////////////////////////////
    // Flag registers

    logic takeTimer;

    // Software write first, then vector clear, then hardware set wins
    always_comb begin
        flagsFourNext = flagsFourReg;
        flagsFiveNext = flagsFiveReg;
        takeTimer     = vectorAck & irqReg.req;
        // A written 1 raises a request as its source would
        if (wrLow && wbReq.adr == `OFS_FLAGS_FOUR) begin
            flagsFourNext = wrData;
        end
        if (wrLow && wbReq.adr == `OFS_FLAGS_FIVE) begin
            flagsFiveNext = wrData;
        end
        // Only timer flags clear on vectoring
        if (takeTimer) begin
            case (irqReg.num)
                `NUM_TIMER_ONE:   flagsFourNext[`BIT_TIMER_ONE] = 1'b0;
                `NUM_TIMER_TWO:   flagsFourNext[`BIT_TIMER_TWO] = 1'b0;
                `NUM_TIMER_THREE: flagsFourNext[`BIT_TIMER_THREE] = 1'b0;
                `NUM_TIMER_FOUR:  flagsFourNext[`BIT_TIMER_FOUR] = 1'b0;
                default:          flagsFourNext = flagsFourNext;
            endcase
        end
        // Hardware sets last so a same-cycle clear never loses an event
        flagsFourNext[`BIT_SLEEP_TIMER] |= hwSet.sleepTimer;
        flagsFourNext[`BIT_PORT_ZERO]   |= hwSet.portZero;
        flagsFourNext[`BIT_TIMER_FOUR]  |= hwSet.timerFour;
        flagsFourNext[`BIT_TIMER_THREE] |= hwSet.timerThree;
        flagsFourNext[`BIT_TIMER_TWO]   |= hwSet.timerTwo;
        flagsFourNext[`BIT_TIMER_ONE]   |= hwSet.timerOne;
        flagsFourNext[`BIT_DMA_DONE]    |= hwSet.dmaDone;

        // Shared sources land on one flag
        flagsFiveNext[`BIT_WATCHDOG]    |= hwSet.watchdog;
        flagsFiveNext[`BIT_PORT_ONE]    |= hwSet.portOne;
        flagsFiveNext[`BIT_SERIAL_B_TX] |= hwSet.serialBTx | hwSet.audioTx;
        flagsFiveNext[`BIT_SERIAL_A_TX] |= hwSet.serialATx;
        flagsFiveNext[`BIT_PORT_TWO]    |= hwSet.portTwo | hwSet.usbCtrl;
        // Unused upper bits never hold a one
        flagsFiveNext = flagsFiveNext & `MASK_FLAGS_FIVE;
    end

    // Flag registers, all clear at reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            flagsFourReg <= `RST_FLAGS;
            flagsFiveReg <= `RST_FLAGS;
        end else begin
            flagsFourReg <= flagsFourNext;
            flagsFiveReg <= flagsFiveNext;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Priority registers

    // One bit per group in each register
    always_comb begin
        prioLowNext  = prioLowReg;
        prioHighNext = prioHighReg;
        if (wrLow && wbReq.adr == `OFS_PRIO_LOW) begin
            prioLowNext = wrData[5:0];
        end
        if (wrLow && wbReq.adr == `OFS_PRIO_HIGH) begin
            prioHighNext = wrData[5:0];
        end
    end

    // All groups start at the lowest level
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prioLowReg  <= `RST_PRIO;
            prioHighReg <= `RST_PRIO;
        end else begin
            prioLowReg  <= prioLowNext;
            prioHighReg <= prioHighNext;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pending vector by interrupt number

    logic [17:0] pending;
    logic [17:0] ownMask;

    // Own flags replace the outside levels at their numbers
    always_comb begin
        pending = 18'h0_0000;
        ownMask = 18'h0_0000;
        pending[`NUM_DMA]         = flagsFourReg[`BIT_DMA_DONE];
        pending[`NUM_TIMER_ONE]   = flagsFourReg[`BIT_TIMER_ONE];
        pending[`NUM_TIMER_TWO]   = flagsFourReg[`BIT_TIMER_TWO];
        pending[`NUM_TIMER_THREE] = flagsFourReg[`BIT_TIMER_THREE];
        pending[`NUM_TIMER_FOUR]  = flagsFourReg[`BIT_TIMER_FOUR];
        pending[`NUM_PORT_ZERO]   = flagsFourReg[`BIT_PORT_ZERO];
        pending[`NUM_SLEEP_TIMER] = flagsFourReg[`BIT_SLEEP_TIMER];
        pending[`NUM_PORT_TWO]    = flagsFiveReg[`BIT_PORT_TWO];
        pending[`NUM_SERIAL_A_TX] = flagsFiveReg[`BIT_SERIAL_A_TX];
        pending[`NUM_SERIAL_B_TX] = flagsFiveReg[`BIT_SERIAL_B_TX];
        pending[`NUM_PORT_ONE]    = flagsFiveReg[`BIT_PORT_ONE];
        pending[`NUM_WATCHDOG]    = flagsFiveReg[`BIT_WATCHDOG];

        // Numbers held here ignore outside levels
        ownMask[`NUM_DMA]         = 1'b1;
        ownMask[`NUM_TIMER_ONE]   = 1'b1;
        ownMask[`NUM_TIMER_TWO]   = 1'b1;
        ownMask[`NUM_TIMER_THREE] = 1'b1;
        ownMask[`NUM_TIMER_FOUR]  = 1'b1;
        ownMask[`NUM_PORT_ZERO]   = 1'b1;
        ownMask[`NUM_SLEEP_TIMER] = 1'b1;
        ownMask[`NUM_PORT_TWO]    = 1'b1;
        ownMask[`NUM_SERIAL_A_TX] = 1'b1;
        ownMask[`NUM_SERIAL_B_TX] = 1'b1;
        ownMask[`NUM_PORT_ONE]    = 1'b1;
        ownMask[`NUM_WATCHDOG]    = 1'b1;
        pending = pending | (otherPending & ~ownMask);
    end

    ////////////////////////////////////////////////////////////////////
    // Arbitration and nesting

    // Winner so far and candidate under test
    logic       found;
    logic [4:0] bestNum;
    level_t     bestLevel;
    level_t     candLevel;
    logic [4:0] candNum;
    logic [2:0] candGroup;
    logic       allowed;

    // Walk the polling order; only a strictly higher level displaces,
    // so among equal levels the earlier polled number keeps the slot
    // A full walk keeps the order plain; 18 places is cheap
    always_comb begin
        found     = 1'b0;
        bestNum   = 5'h00;
        bestLevel = 2'h0;
        candLevel = 2'h0;
        candNum   = 5'h00;
        candGroup = 3'h0;
        for (int p = 0; p < NUM_IRQS; p++) begin
            candNum   = pollNum(5'(p));
            candGroup = groupOf(candNum);
            candLevel = {prioHighReg[candGroup], prioLowReg[candGroup]};
            if (pending[candNum] && (!found || candLevel > bestLevel)) begin
                found     = 1'b1;
                bestNum   = candNum;
                bestLevel = candLevel;
            end
        end
    end

    // A routine in service holds off equal or lower levels
    // An empty nesting mask lets any level through
    assign allowed = (activeReg == 4'h0) || (bestLevel > topLevel(activeReg));

    // Nesting mask and request register
    always_comb begin
        activeNext = activeReg;
        // A return pops the innermost, highest level
        if (retiPulse && activeReg != 4'h0) begin
            activeNext[topLevel(activeReg)] = 1'b0;
        end
        if (vectorAck && irqReg.req) begin
            activeNext[irqReg.level] = 1'b1;
        end
        // Drop in the take cycle so it is not taken twice
        irqNext.req   = found & allowed & ~vectorAck;
        irqNext.num   = bestNum;
        irqNext.level = bestLevel;
    end

    // Request and nesting state, idle at reset
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            activeReg <= 4'h0;
            irqReg    <= '0;
        end else begin
            activeReg <= activeNext;
            irqReg    <= irqNext;
        end
    end

    // Outputs straight from registers
    assign irqOut       = irqReg;
    assign activeLevels = activeReg;

endmodule

`default_nettype wire

// File: tb/irq_flags_and_priority_properties.sv
/*
 Checker for the interrupt flag and priority block, bound to its top.
 Assumes the package port types and one core clock domain.
*/
`timescale 1ns/1ps
`include "irq_flags_defines.svh"
`default_nettype none

module irq_flags_and_priority_properties
    import irq_flags_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        sys_rst,
    input wire wb_req_t     wbReq,
    input wire wb_rsp_t     wbRsp,
    input wire hw_set_t     hwSet,
    input wire logic [17:0] otherPending,
    input wire logic        vectorAck,
    input wire logic        retiPulse,
    input wire irq_out_t    irqOut,
    input wire logic [3:0]  activeLevels
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    logic prioSeen_reg;
    logic prioSeen_next;
    // Until software writes a priority register every group stays lowest
    always_comb begin
        prioSeen_next = prioSeen_reg;
        if (wbReq.we && wbRsp.ack && (wbReq.adr == `OFS_PRIO_LOW || wbReq.adr == `OFS_PRIO_HIGH)) begin
            prioSeen_next = 1'b1;
        end
    end
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prioSeen_reg <= 1'b0;
        end else begin
            prioSeen_reg <= prioSeen_next;
        end
    end
    AST_ACK_NEXT: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
        else $error("bus request not answered next cycle");
    AST_ACK_ONCE: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wbRsp.ack |-> wbRsp.dat == 32'h0)
        else $error("read data outside ack");
    AST_FIVE_UNUSED: assert property (wbRsp.ack && !wbReq.we && wbReq.adr == `OFS_FLAGS_FIVE
        |-> wbRsp.dat[31:5] == 27'h0) else $error("unused flag bits read nonzero");
    AST_NO_PREEMPT: assert property (irqOut.req |-> (activeLevels & (4'hF << irqOut.level)) == 4'h0)
        else $error("request presented at or below active level");
    AST_VECTOR_DROP: assert property (vectorAck && irqOut.req |=> !irqOut.req)
        else $error("request held after vectoring");
    AST_VECTOR_MARK: assert property (vectorAck && irqOut.req |=> activeLevels[$past(irqOut.level)])
        else $error("taken level not marked active");
    AST_RETI_POP: assert property (retiPulse && !vectorAck && activeLevels != 4'h0
        |=> activeLevels < $past(activeLevels)) else $error("return left active levels");
    AST_LEVEL_HOLD: assert property (!vectorAck && !retiPulse |=> $stable(activeLevels))
        else $error("active levels moved without cause");
    AST_RESET_LOWEST: assert property (irqOut.req && !prioSeen_reg |-> irqOut.level == 2'h0)
        else $error("level above lowest before priority write");
    // Main scenarios
    cover property (vectorAck && irqOut.req);
    cover property (activeLevels == 4'h3);
    cover property (retiPulse && activeLevels != 4'h0);
endmodule

bind irq_flags_and_priority irq_flags_and_priority_properties props (
    .core_clk     (core_clk),
    .sys_rst      (sys_rst),
    .wbReq        (wbReq),
    .wbRsp        (wbRsp),
    .hwSet        (hwSet),
    .otherPending (otherPending),
    .vectorAck    (vectorAck),
    .retiPulse    (retiPulse),
    .irqOut       (irqOut),
    .activeLevels (activeLevels)
);
`default_nettype wire

// File: tb/core_model.sv
/*
 Behavioural processor core that takes presented requests and returns.
 Assumes registered irqOut on core_clk; one timer for the innermost routine.
*/
`timescale 1ns/1ps
`default_nettype none

module core_model
    import irq_flags_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       sys_rst,
    input  wire irq_out_t   irqOut,
    input  wire logic       ackEn,
    input  wire logic [7:0] serviceLen,
    output var  logic       vectorAck,
    output var  logic       retiPulse,
    output var  logic [4:0] takenNum
);
    logic [2:0] depth_reg;
    logic [7:0] timeLeft_reg;
    logic       takeNow;
    // Never take in a return cycle, so the two pulses stay apart
    assign takeNow = irqOut.req && ackEn && !vectorAck && !retiPulse;
    // A take restarts the timer, so outer routines run long when nested
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            vectorAck    <= 1'b0;
            retiPulse    <= 1'b0;
            takenNum     <= 5'h00;
            depth_reg    <= 3'h0;
            timeLeft_reg <= 8'h00;
        end else begin
            vectorAck <= takeNow;
            retiPulse <= 1'b0;
            if (takeNow) begin
                takenNum     <= irqOut.num;
                depth_reg    <= depth_reg + 3'h1;
                timeLeft_reg <= serviceLen;
            end else if (depth_reg != 3'h0 && timeLeft_reg == 8'h00) begin
                retiPulse    <= 1'b1;
                depth_reg    <= depth_reg - 3'h1;
                timeLeft_reg <= serviceLen;
            end else if (depth_reg != 3'h0) begin
                timeLeft_reg <= timeLeft_reg - 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/irq_flags_and_priority_test.sv
/*
 Self-checking bench for the interrupt flag and priority block.
 Assumes the core model and the bound checker beside it.
*/
`timescale 1ns/1ps
`include "irq_flags_defines.svh"
`default_nettype none

module irq_flags_and_priority_test
    import irq_flags_pkg::*;
();
    logic core_clk, sys_rst, vectorAck, retiPulse, ackEn;
    wb_req_t     wbReq;
    wb_rsp_t     wbRsp;
    hw_set_t     hwSet;
    irq_out_t    irqOut;
    logic [3:0]  activeLevels;
    logic [7:0]  serviceLen;
    logic [4:0]  takenNum;
    logic [31:0] rd;
    logic [17:0] otherPending;
    int          numErrors;
    int          compares;
    // Expected {five, four} per set input, usbCtrl first
    localparam logic [15:0] FLAG_MAP [0:13] = '{16'h0100, 16'h0100, 16'h0200, 16'h0400, 16'h0400, 16'h0800,
        16'h1000, 16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020, 16'h0080};
    irq_flags_and_priority DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wbReq(wbReq), .wbRsp(wbRsp),
        .hwSet(hwSet), .otherPending(otherPending), .vectorAck(vectorAck), .retiPulse(retiPulse),
        .irqOut(irqOut), .activeLevels(activeLevels));
    core_model CORE (.core_clk(core_clk), .sys_rst(sys_rst), .irqOut(irqOut), .ackEn(ackEn),
        .serviceLen(serviceLen), .vectorAck(vectorAck), .retiPulse(retiPulse), .takenNum(takenNum));
    initial begin
        core_clk = 1'b0;
        forever begin
            #5 core_clk = ~core_clk;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testDone();
        $display("errors %0d compares %0d", numErrors, compares);
        if (numErrors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // A used-up bound counts as a mismatch and ends the run
    task automatic limit(input int n);
        if (n >= 300) begin
            numErrors++;
            $display("BAD wait expected done seen timeout");
            testDone();
        end
    endtask
    // Held until ack, then released for one cycle
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        wbReq <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
        do begin
            @(posedge core_clk);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 300);
        rd = wbRsp.dat;
        wbReq <= '0;
        @(posedge core_clk);
        limit(n);
    endtask
    task automatic expectReg(input logic [7:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        check($sformatf("reg %h", adr), exp, rd);
    endtask
    task automatic expectIrq(input logic [4:0] num, input level_t lvl);
        repeat (2) @(posedge core_clk);
        check("irq", {24'h0, 1'b1, num, lvl}, {24'h0, irqOut});
    endtask
    task automatic pulse(input logic [13:0] s);
        hwSet <= hw_set_t'(s);
        @(posedge core_clk);
        hwSet <= '0;
        @(posedge core_clk);
    endtask
    // Either a presented request or a given set of active levels
    task automatic waitFor(input logic useReq, input logic [3:0] act);
        int n;
        n = 0;
        while ((useReq ? irqOut.req !== 1'b1 : activeLevels !== act) && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        limit(n);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic testReset();
        expectReg(`OFS_FLAGS_FOUR, 32'h0);
        expectReg(`OFS_FLAGS_FIVE, 32'h0);
        expectReg(`OFS_PRIO_LOW, 32'h0);
        expectReg(`OFS_PRIO_HIGH, 32'h0);
        bus(1'b1, 8'h44, 32'h000000FF);
        expectReg(8'h44, 32'h0);
        bus(1'b1, `OFS_FLAGS_FIVE, 32'h000000FF);
        expectReg(`OFS_FLAGS_FIVE, 32'h0000001F);
        bus(1'b1, `OFS_FLAGS_FIVE, 32'h0);
    endtask
    // Each source lands on its flag, shared sources on one bit, and stays there
    task automatic testFlags();
        for (int i = 0; i < 14; i++) begin
            pulse(14'h0001 << i);
            repeat (4) @(posedge core_clk);
            expectReg(`OFS_FLAGS_FOUR, {24'h0, FLAG_MAP[i][7:0]});
            expectReg(`OFS_FLAGS_FIVE, {24'h0, FLAG_MAP[i][15:8]});
            bus(1'b1, `OFS_FLAGS_FOUR, 32'h0);
            bus(1'b1, `OFS_FLAGS_FIVE, 32'h0);
        end
        bus(1'b1, `OFS_FLAGS_FOUR, 32'h00000020);
        waitFor(1'b1, 4'h0);
        expectIrq(`NUM_PORT_ZERO, 2'h0);
        bus(1'b1, `OFS_FLAGS_FOUR, 32'h0);
    endtask
    // Timer flag cleared by vectoring, DMA flag kept
    task automatic testVector();
        ackEn <= 1'b1;
        pulse(14'h0100);
        waitFor(1'b0, 4'h1);
        check("taken", {27'h0, `NUM_TIMER_ONE}, {27'h0, takenNum});
        expectReg(`OFS_FLAGS_FOUR, 32'h0);
        waitFor(1'b0, 4'h0);
        pulse(14'h0080);
        waitFor(1'b0, 4'h1);
        ackEn <= 1'b0;
        expectReg(`OFS_FLAGS_FOUR, 32'h00000001);
        bus(1'b1, `OFS_FLAGS_FOUR, 32'h0);
        waitFor(1'b0, 4'h0);
    endtask
    // Level encoding, polling order on ties, level before order
    task automatic testPrio();
        pulse(14'h0100);
        for (int l = 0; l < 4; l++) begin
            bus(1'b1, `OFS_PRIO_LOW, {30'h0, l[0], 1'b0});
            bus(1'b1, `OFS_PRIO_HIGH, {30'h0, l[1], 1'b0});
            expectReg(`OFS_PRIO_HIGH, {30'h0, l[1], 1'b0});
            expectIrq(`NUM_TIMER_ONE, 2'(l));
        end
        bus(1'b1, `OFS_PRIO_LOW, 32'h0);
        bus(1'b1, `OFS_PRIO_HIGH, 32'h0);
        pulse(14'h2080);
        expectIrq(`NUM_DMA, 2'h0);
        otherPending <= 18'h10000;
        expectIrq(5'h10, 2'h0);
        otherPending <= 18'h00100;
        bus(1'b1, `OFS_FLAGS_FOUR, 32'h00000082);
        expectIrq(`NUM_TIMER_ONE, 2'h0);
        otherPending <= 18'h00000;
        bus(1'b1, `OFS_PRIO_LOW, 32'h00000020);
        bus(1'b1, `OFS_PRIO_HIGH, 32'h00000020);
        expectIrq(`NUM_SLEEP_TIMER, 2'h3);
        bus(1'b1, `OFS_FLAGS_FOUR, 32'h0);
    endtask
    // Same level waits behind the routine, a higher level preempts it
    task automatic testNest();
        serviceLen <= 8'h3C;
        ackEn <= 1'b1;
        pulse(14'h0100);
        waitFor(1'b0, 4'h1);
        pulse(14'h0080);
        repeat (4) @(posedge core_clk);
        check("blocked", 32'h0, {31'h0, irqOut.req});
        bus(1'b1, `OFS_PRIO_LOW, 32'h00000001);
        waitFor(1'b0, 4'h3);
        check("nested", {27'h0, `NUM_DMA}, {27'h0, takenNum});
        expectReg(`OFS_SERVICE, 32'h00002103);
        ackEn <= 1'b0;
        bus(1'b1, `OFS_FLAGS_FOUR, 32'h0);
        waitFor(1'b0, 4'h0);
    endtask
    initial begin
        sys_rst = 1'b1;
        wbReq = '0;
        hwSet = '0;
        otherPending = 18'h00000;
        ackEn = 1'b0;
        serviceLen = 8'h08;
        numErrors = 0;
        compares = 0;
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        testReset();
        testFlags();
        testVector();
        testPrio();
        testNest();
        testDone();
    end
endmodule
`default_nettype wire
